// File: design/dcfs_decide.sv
// Omnipolar threshold evaluation with hysteresis.
`timescale 1ns/1ps
module dcfs_decide (
	input  wire logic              clk,
	input  wire logic              resetn,
	input  wire logic              step,
	input  wire logic              first,
	input  wire dcfs_pkg::dcfs_cmp_s cmp,
	input  wire logic              field_on_prev,
	output logic                   field_on_r
);
	import dcfs_pkg::*;

	// ==========================================================
	// Sequential questioning of operate then release points.
	logic op_hit_r;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			op_hit_r <= 1'b0;
		end else if (step && first) begin
			op_hit_r <= cmp.south_over_op | cmp.north_over_op;
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			field_on_r <= 1'b0;
		end else if (step && !first) begin
			if (op_hit_r) begin
				field_on_r <= 1'b1;
			end else if (!(cmp.south_over_rel | cmp.north_over_rel)) begin
				field_on_r <= 1'b0;
			end else begin
				field_on_r <= field_on_prev;
			end
		end
	end
endmodule

// File: design/dcfs_seq.sv
// Duty-cycled sequencer with latched open-drain output.
`timescale 1ns/1ps
`include "dcfs_defs.svh"

module dcfs_seq #(
	parameter int OP_CYC  = `DCFS_OP_CYC,
	parameter int STB_CYC = `DCFS_STB_CYC,
	parameter int STU_CYC = `DCFS_STU_CYC
) (
	input  wire logic                clk,
	input  wire logic                resetn,
	input  wire logic                polarity_select,
	input  wire dcfs_pkg::dcfs_cmp_s cmp_in,
	output logic                     sense_power_r,
	output logic                     q_out_r,
	output logic                     q_oe_r,
	output logic                     q_valid_r
);
	import dcfs_pkg::*;

	// Refuses timings that leave no room for both sample steps.
	if (OP_CYC < 4 || STU_CYC < 1 || STU_CYC >= OP_CYC - 2 || STB_CYC < 1) begin : g_bad_timing
		$error("dcfs_seq: unusable timing parameters");
	end

	// ==========================================================
	// Pin synchronisers.
	logic       prg_s1_r;
	logic       prg_s2_r;
	dcfs_cmp_s  cmp_s1_r;
	dcfs_cmp_s  cmp_s2_r;

	always_ff @(posedge clk) begin
		prg_s1_r <= polarity_select;
		prg_s2_r <= prg_s1_r;
		cmp_s1_r <= cmp_in;
		cmp_s2_r <= cmp_s1_r;
	end

	// ==========================================================
	// Phase sequencer.
	dcfs_state_e state_r;
	logic [31:0] cnt_r;
	logic        step;
	logic        first;
	logic        end_op;
	logic        field_on_r;

	assign end_op = (state_r == DCFS_ST_OPERATE) && (cnt_r == 32'(OP_CYC - 1));
	assign first  = (cnt_r == 32'(OP_CYC - 3));
	assign step   = (state_r == DCFS_ST_OPERATE) && (first || cnt_r == 32'(OP_CYC - 2));

	always_ff @(posedge clk) begin
		if (!resetn) begin
			state_r <= DCFS_ST_STARTUP;
			cnt_r   <= 32'h0;
		end else begin
			case (state_r)
				DCFS_ST_STARTUP: begin
					if (cnt_r == 32'(STU_CYC - 1)) begin
						state_r <= DCFS_ST_OPERATE;
					end
					cnt_r <= cnt_r + 32'h1;
				end
				DCFS_ST_OPERATE: begin
					if (end_op) begin
						state_r <= DCFS_ST_STANDBY;
						cnt_r   <= 32'h0;
					end else begin
						cnt_r <= cnt_r + 32'h1;
					end
				end
				DCFS_ST_STANDBY: begin
					if (cnt_r == 32'(STB_CYC - 1)) begin
						state_r <= DCFS_ST_OPERATE;
						cnt_r   <= 32'h0;
					end else begin
						cnt_r <= cnt_r + 32'h1;
					end
				end
				default: begin
					state_r <= DCFS_ST_STARTUP;
					cnt_r   <= 32'h0;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			sense_power_r <= 1'b1;
		end else begin
			sense_power_r <= !end_op &&
				!((state_r == DCFS_ST_STANDBY) && (cnt_r != 32'(STB_CYC - 1)));
		end
	end

	// ==========================================================
	// Threshold evaluation.
	logic field_latched_r;

	dcfs_decide u_decide (
		.clk           (clk),
		.resetn        (resetn),
		.step          (step),
		.first         (first),
		.cmp           (cmp_s2_r),
		.field_on_prev (field_latched_r),
		.field_on_r    (field_on_r)
	);

	// ==========================================================
	// Output latch and open-drain stage.
	logic q_level;

	assign q_level = field_on_r ? !prg_s2_r : prg_s2_r;

	always_ff @(posedge clk) begin
		if (!resetn) begin
			field_latched_r <= 1'b0;
			q_out_r         <= 1'b0;
			q_oe_r          <= 1'b0;
			q_valid_r       <= 1'b0;
		end else if (end_op) begin
			field_latched_r <= field_on_r;
			q_out_r         <= 1'b0;
			q_oe_r          <= !q_level;
			q_valid_r       <= 1'b1;
		end
	end

	// ==========================================================
	// Checks.
	// Helper count of cycles spent in the current operate window.
	logic [31:0] op_run_r;

	always_ff @(posedge clk) begin
		if (!resetn || state_r != DCFS_ST_OPERATE) begin
			op_run_r <= 32'h0;
		end else begin
			op_run_r <= op_run_r + 32'h1;
		end
	end

	property p_hold_in_standby;
		@(posedge clk) disable iff (!resetn)
		(state_r == DCFS_ST_STANDBY) && !$past(end_op) |-> $stable(q_oe_r);
	endproperty
	a_hold_in_standby: assert property (p_hold_in_standby) else $error("output moved in standby");

	property p_standby_follows_op;
		@(posedge clk) disable iff (!resetn)
		end_op |=> (state_r == DCFS_ST_STANDBY) && q_valid_r;
	endproperty
	a_standby_follows_op: assert property (p_standby_follows_op) else $error("no standby after operate");

	property p_op_ends_by_count;
		@(posedge clk) disable iff (!resetn)
		(state_r == DCFS_ST_OPERATE) |-> (op_run_r < 32'(OP_CYC));
	endproperty
	a_op_ends_by_count: assert property (p_op_ends_by_count) else $error("operate window too long");

	property p_drain_only_low;
		@(posedge clk) disable iff (!resetn)
		q_oe_r |-> !q_out_r;
	endproperty
	a_drain_only_low: assert property (p_drain_only_low) else $error("drive while high");

	property p_idle_level;
		@(posedge clk) disable iff (!resetn)
		end_op && !field_on_r |=> (q_oe_r == !$past(prg_s2_r));
	endproperty
	a_idle_level: assert property (p_idle_level) else $error("zero field level wrong");

	property p_field_level;
		@(posedge clk) disable iff (!resetn)
		end_op && field_on_r |=> (q_oe_r == $past(prg_s2_r));
	endproperty
	a_field_level: assert property (p_field_level) else $error("field level wrong");

	property p_startup_first;
		@(posedge clk) disable iff (!resetn)
		$rose(resetn) |-> (state_r == DCFS_ST_STARTUP);
	endproperty
	a_startup_first: assert property (p_startup_first) else $error("no start-up interval");

	property p_sense_off_standby;
		@(posedge clk) disable iff (!resetn)
		(state_r == DCFS_ST_STANDBY) |-> !sense_power_r;
	endproperty
	a_sense_off_standby: assert property (p_sense_off_standby) else $error("sensing on in standby");

	property p_sense_on_operate;
		@(posedge clk) disable iff (!resetn)
		(state_r == DCFS_ST_OPERATE) |-> sense_power_r;
	endproperty
	a_sense_on_operate: assert property (p_sense_on_operate) else $error("sensing off in operate");
endmodule

// File: include/dcfs_defs.svh
// Timing and polarity constants for the duty-cycled field switch sequencer.
`ifndef DCFS_DEFS_SVH
`define DCFS_DEFS_SVH

`define DCFS_CLK_MHZ        125
`define DCFS_OP_WIN_US      50
`define DCFS_OP_MIN_US      15
`define DCFS_OP_MAX_US      93
`define DCFS_STB_WIN_MS     130
`define DCFS_STB_MAX_MS     240
`define DCFS_STU_US         6
`define DCFS_STU_MAX_US     12
`define DCFS_OP_CYC         (`DCFS_OP_WIN_US * `DCFS_CLK_MHZ)
`define DCFS_STB_CYC        (`DCFS_STB_WIN_MS * 1000 * `DCFS_CLK_MHZ)
`define DCFS_STU_CYC        (`DCFS_STU_US * `DCFS_CLK_MHZ)
`define DCFS_OUT_IDLE_HIGH  1'b1

`endif

// File: include/dcfs_pkg.sv
// Types shared by the duty-cycled field switch sequencer.
package dcfs_pkg;

	typedef enum logic [1:0] {
		DCFS_ST_STARTUP = 2'b00,
		DCFS_ST_OPERATE = 2'b01,
		DCFS_ST_STANDBY = 2'b10
	} dcfs_state_e;

	typedef struct packed {
		logic south_over_op;
		logic north_over_op;
		logic south_over_rel;
		logic north_over_rel;
	} dcfs_cmp_s;

endpackage

// File: sim/dcfs_host.sv
// Host digital input with pull-up reading the open-drain output.
`timescale 1ns/1ps
module dcfs_host (
	input  wire logic q_oe_r,
	output logic      pin_level
);
	// The pull-up gives high whenever the transistor does not sink.
	assign pin_level = q_oe_r ? 1'b0 : 1'b1;
endmodule

// File: sim/tb.sv
// Self-checking testbench for the duty-cycled field switch sequencer.
`timescale 1ns/1ps
module tb;
	import dcfs_pkg::*;
	localparam int OP  = 20;
	localparam int STB = 50;
	localparam int STU = 4;
	logic      clk             = 1'b0;
	logic      resetn          = 1'b0;
	logic      polarity_select = 1'b1;
	dcfs_cmp_s cmp_in          = '0;
	logic      sense_power_r;
	logic      q_out_r;
	logic      q_oe_r;
	logic      q_valid_r;
	logic      pin_level;
	int        mismatches      = 0;
	int        tests_run       = 0;
	always #4 clk = ~clk;
	dcfs_seq #(.OP_CYC(OP), .STB_CYC(STB), .STU_CYC(STU)) u_dut (
		.clk             (clk),
		.resetn          (resetn),
		.polarity_select (polarity_select),
		.cmp_in          (cmp_in),
		.sense_power_r   (sense_power_r),
		.q_out_r         (q_out_r),
		.q_oe_r          (q_oe_r),
		.q_valid_r       (q_valid_r)
	);
	dcfs_host u_host (
		.q_oe_r    (q_oe_r),
		.pin_level (pin_level)
	);
	// ==========================================================
	// Shared tasks
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic stop_test();
		$display("mismatches %0d tests_run %0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// Runs out any standby and the next operate window, watching the pin stay put.
	task automatic win(output int nst, output int nop);
		logic held;
		nst = 0;
		nop = 0;
		held = pin_level;
		while (!sense_power_r && nst < 1000) begin
			@(negedge clk);
			nst++;
			if (pin_level !== held) chk("pin held", pin_level, held);
		end
		while (sense_power_r && nop < 1000) begin
			if (pin_level !== held) chk("pin held", pin_level, held);
			@(negedge clk);
			nop++;
		end
	endtask
	task automatic step(input logic p, input logic [3:0] c, input logic exp);
		int nst;
		int nop;
		@(posedge clk);
		polarity_select <= p;
		cmp_in <= dcfs_cmp_s'(c);
		win(nst, nop);
		chk("standby len", nst >= STB - 1 && nst <= STB + 1, 1'b1);
		chk("operate len", nop >= OP - 1 && nop <= OP + 1, 1'b1);
		chk("pin", pin_level, exp);
		chk("q_out", q_out_r, 1'b0);
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_powerup();
		int nst;
		int nop;
		chk("valid at reset", q_valid_r, 1'b0);
		chk("pin at reset", pin_level, 1'b1);
		chk("power at reset", sense_power_r, 1'b1);
		win(nst, nop);
		chk("first window", nop >= OP - 1 && nop <= OP + 1, 1'b1);
		chk("valid", q_valid_r, 1'b1);
		chk("idle high", pin_level, 1'b1);
	endtask
	task automatic t_omni();
		step(1'b1, 4'ha, 1'b0);
		step(1'b1, 4'h5, 1'b0);
	endtask
	task automatic t_hyst();
		step(1'b1, 4'h2, 1'b0);
		step(1'b1, 4'h0, 1'b1);
	endtask
	task automatic t_invert();
		step(1'b0, 4'h0, 1'b0);
		step(1'b0, 4'h5, 1'b1);
		chk("sink off", q_oe_r, 1'b0);
		step(1'b0, 4'h0, 1'b0);
	endtask
	// Power-up again in mid-run, back to the standard polarity.
	task automatic t_reset();
		@(posedge clk);
		resetn <= 1'b0;
		polarity_select <= 1'b1;
		cmp_in <= '0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		@(negedge clk);
		t_powerup();
	endtask
	// ==========================================================
	// Main sequence and watchdog
	initial begin
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		@(negedge clk);
		t_powerup();
		t_omni();
		t_hyst();
		t_invert();
		t_reset();
		stop_test();
	end
	initial begin
		#100000;
		mismatches++;
		stop_test();
	end
endmodule
